//--- core/atsc_regs.sv
/*
 * Register bank for test patterns, signature readback, over-range pin enables,
 * channel source assignment, divider sync control and miscellaneous control.
 * Assumes a synchronous single-cycle register port and a channel index input.
 */
`timescale 1ns/1ps
module atsc_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [8:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// Channel index, bit 0 for A, bit 1 for B
	input wire logic [1:0] chanIndex,
	// Datapath status
	input wire logic [7:0] signatureIn,
	input wire logic syncPulse,
	input wire logic lowRateDetected,
	input wire logic outputEnablePinN,
	// Control outputs
	output logic [15:0] userPattern1,
	output logic [15:0] userPattern2,
	output logic [1:0] overrangePinEnable,
	output logic [1:0] channelSourceB,
	output logic dividerAlign,
	output logic oscillatorRun,
	output logic dataOutputsEnabled,
	output logic sdioPulldownDisable
);
	typedef struct packed {
		logic [7:0] rdata;
		logic [15:0] pat1;
		logic [15:0] pat2;
		logic [7:0] sig;
		logic [1:0] orEn;
		logic [1:0] src;
		logic [7:0] sync;
		logic [7:0] misc;
		logic align;
		logic osc;
		logic oe;
	} atsc_state_type;

	atsc_state_type s_q;
	atsc_state_type s_d;
	logic syncFire;

	// Reads an indexed bit, giving the OR of every selected channel.
	function automatic logic [7:0] readIndexed(input logic [1:0] bits, input logic [1:0] sel);
		readIndexed = {7'h00, |(bits & sel)};
	endfunction : readIndexed

	// Tells whether an address belongs to this bank.
	function automatic logic isMapped(input logic [8:0] a);
		isMapped = a inside {atsc_pkg::ADDR_PATTERN1_LOW, atsc_pkg::ADDR_PATTERN1_HIGH,
			atsc_pkg::ADDR_PATTERN2_LOW, atsc_pkg::ADDR_PATTERN2_HIGH,
			atsc_pkg::ADDR_SIGNATURE_LOW, atsc_pkg::ADDR_OVERRANGE_CTRL,
			atsc_pkg::ADDR_CHANNEL_SOURCE, atsc_pkg::ADDR_SYNC_CTRL, atsc_pkg::ADDR_MISC_CTRL};
	endfunction : isMapped

	always_comb begin
		s_d = s_q;
		s_d.align = 1'b0;
		s_d.sig = signatureIn;
		if (regRead) begin
			case (regAddr)
				atsc_pkg::ADDR_PATTERN1_LOW: s_d.rdata = s_q.pat1[7:0];
				atsc_pkg::ADDR_PATTERN1_HIGH: s_d.rdata = s_q.pat1[15:8];
				atsc_pkg::ADDR_PATTERN2_LOW: s_d.rdata = s_q.pat2[7:0];
				atsc_pkg::ADDR_PATTERN2_HIGH: s_d.rdata = s_q.pat2[15:8];
				atsc_pkg::ADDR_SIGNATURE_LOW: s_d.rdata = s_q.sig;
				atsc_pkg::ADDR_OVERRANGE_CTRL: s_d.rdata = readIndexed(s_q.orEn, chanIndex);
				atsc_pkg::ADDR_CHANNEL_SOURCE: s_d.rdata = readIndexed(s_q.src, chanIndex);
				atsc_pkg::ADDR_SYNC_CTRL: s_d.rdata = s_q.sync;
				atsc_pkg::ADDR_MISC_CTRL: s_d.rdata = s_q.misc;
				default: s_d.rdata = 8'h00;
			endcase
		end
		if (regWrite) begin
			case (regAddr)
				atsc_pkg::ADDR_PATTERN1_LOW: s_d.pat1[7:0] = regWdata;
				atsc_pkg::ADDR_PATTERN1_HIGH: s_d.pat1[15:8] = regWdata;
				atsc_pkg::ADDR_PATTERN2_LOW: s_d.pat2[7:0] = regWdata;
				atsc_pkg::ADDR_PATTERN2_HIGH: s_d.pat2[15:8] = regWdata;
				atsc_pkg::ADDR_OVERRANGE_CTRL: begin
					for (int i = 0; i < 2; i++) begin
						if (chanIndex[i]) begin
							s_d.orEn[i] = regWdata[0];
						end
					end
				end
				atsc_pkg::ADDR_CHANNEL_SOURCE: begin
					for (int i = 0; i < 2; i++) begin
						if (chanIndex[i]) begin
							s_d.src[i] = regWdata[0];
						end
					end
				end
				atsc_pkg::ADDR_SYNC_CTRL: s_d.sync = regWdata & atsc_pkg::SYNC_WRITE_MASK;
				atsc_pkg::ADDR_MISC_CTRL: s_d.misc = regWdata & atsc_pkg::MISC_WRITE_MASK;
				default: s_d.rdata = s_d.rdata;
			endcase
		end
		// A sync pulse acts only with master and divider enables set.
		syncFire = syncPulse && s_q.sync[atsc_pkg::SYNC_MASTER_BIT]
			&& s_q.sync[atsc_pkg::SYNC_DIVIDER_BIT];
		if (syncFire) begin
			s_d.align = 1'b1;
			if (s_q.sync[atsc_pkg::SYNC_NEXT_ONLY_BIT]) begin
				s_d.sync[atsc_pkg::SYNC_DIVIDER_BIT] = 1'b0;
			end
		end
		s_d.osc = s_q.misc[atsc_pkg::MISC_RUN_OSC_BIT]
			|| (s_q.misc[atsc_pkg::MISC_DETECT_BIT] && lowRateDetected);
		s_d.oe = s_q.misc[atsc_pkg::MISC_OE_PIN_BIT] ? ~outputEnablePinN : 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q.rdata <= 8'h00;
			s_q.pat1 <= {atsc_pkg::RST_PATTERN, atsc_pkg::RST_PATTERN};
			s_q.pat2 <= {atsc_pkg::RST_PATTERN, atsc_pkg::RST_PATTERN};
			s_q.sig <= 8'h00;
			s_q.orEn <= {2{atsc_pkg::RST_OVERRANGE[0]}};
			s_q.src <= {atsc_pkg::RST_SOURCE_CHAN_B[0], atsc_pkg::RST_SOURCE_CHAN_A[0]};
			s_q.sync <= atsc_pkg::RST_SYNC;
			s_q.misc <= atsc_pkg::RST_MISC;
			s_q.align <= 1'b0;
			s_q.osc <= 1'b0;
			s_q.oe <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdata = s_q.rdata;
	assign userPattern1 = s_q.pat1;
	assign userPattern2 = s_q.pat2;
	assign overrangePinEnable = s_q.orEn;
	assign channelSourceB = s_q.src;
	assign dividerAlign = s_q.align;
	assign oscillatorRun = s_q.osc;
	assign dataOutputsEnabled = s_q.oe;
	assign sdioPulldownDisable = s_q.misc[atsc_pkg::MISC_PULLDOWN_DIS_BIT];

	AST_NEXT_ONLY_CLEARS: assert property (@(posedge sys_clk) disable iff (rst)
		(syncFire && s_q.sync[2] && !(regWrite && regAddr == atsc_pkg::ADDR_SYNC_CTRL))
		|=> !s_q.sync[1] && s_q.align)
		else $error("divider enable not cleared after single sync");
	AST_CONT_SYNC_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
		(syncFire && !s_q.sync[2] && !regWrite) |=> s_q.sync[1] && s_q.align)
		else $error("continuous sync lost enable");
	AST_NO_MASTER_NO_ALIGN: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(s_q.sync[0]) |-> !s_q.align)
		else $error("align without master enable");
	AST_OSC_RUN: assert property (@(posedge sys_clk) disable iff (rst)
		s_q.misc[2] |=> oscillatorRun)
		else $error("oscillator not forced on");
	AST_OE_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
		!s_q.misc[7] |=> dataOutputsEnabled)
		else $error("pin not ignored");
	AST_SIG_RO: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_SIGNATURE_LOW |=> regRdata == $past(s_q.sig))
		else $error("signature readback wrong");
	AST_PAT1_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_PATTERN1_HIGH |=> userPattern1[15:8] == $past(regWdata))
		else $error("pattern one high byte not written");
	AST_PAT2_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_PATTERN2_LOW |=> userPattern2[7:0] == $past(regWdata))
		else $error("pattern two low byte not written");
	AST_MISC_MASK: assert property (@(posedge sys_clk) disable iff (rst)
		(s_q.misc & 8'h72) == 8'h00 && (s_q.sync & 8'hf8) == 8'h00)
		else $error("reserved bits set");
	AST_OR_INDEX: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_OVERRANGE_CTRL && chanIndex == 2'b01
		|=> overrangePinEnable[1] == $past(overrangePinEnable[1]))
		else $error("unindexed channel changed");
	AST_SRC_INDEX: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_CHANNEL_SOURCE && chanIndex == 2'b10
		|=> channelSourceB[1] == $past(regWdata[0]))
		else $error("source select not written");

	// Read path checks.
	AST_RD_PAT1_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_PATTERN1_LOW |=> regRdata == $past(s_q.pat1[7:0]))
		else $error("pattern one low byte readback wrong");
	AST_RD_PAT1_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_PATTERN1_HIGH |=> regRdata == $past(s_q.pat1[15:8]))
		else $error("pattern one high byte readback wrong");
	AST_RD_PAT2_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_PATTERN2_LOW |=> regRdata == $past(s_q.pat2[7:0]))
		else $error("pattern two low byte readback wrong");
	AST_RD_PAT2_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_PATTERN2_HIGH |=> regRdata == $past(s_q.pat2[15:8]))
		else $error("pattern two high byte readback wrong");
	AST_RD_OVERRANGE: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_OVERRANGE_CTRL
		|=> regRdata == {7'h00, $past(|(s_q.orEn & chanIndex))})
		else $error("over-range enable readback wrong");
	AST_RD_SOURCE: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_CHANNEL_SOURCE
		|=> regRdata == {7'h00, $past(|(s_q.src & chanIndex))})
		else $error("source select readback wrong");
	AST_RD_SYNC: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_SYNC_CTRL |=> regRdata == $past(s_q.sync))
		else $error("sync control readback wrong");
	AST_RD_MISC: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && regAddr == atsc_pkg::ADDR_MISC_CTRL |=> regRdata == $past(s_q.misc))
		else $error("misc control readback wrong");
	AST_RD_UNMAPPED: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && !isMapped(regAddr) |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!regRead |=> $stable(regRdata))
		else $error("read data changed without a read");
	AST_SIG_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> s_q.sig == $past(signatureIn))
		else $error("signature byte not taken from engine");

	// Write path checks.
	AST_PAT1_LOW_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_PATTERN1_LOW |=> userPattern1[7:0] == $past(regWdata))
		else $error("pattern one low byte not written");
	AST_PAT2_HIGH_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_PATTERN2_HIGH
		|=> userPattern2[15:8] == $past(regWdata))
		else $error("pattern two high byte not written");
	AST_PAT1_LOW_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_PATTERN1_LOW) |=> $stable(userPattern1[7:0]))
		else $error("pattern one low byte changed");
	AST_PAT1_HIGH_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_PATTERN1_HIGH) |=> $stable(userPattern1[15:8]))
		else $error("pattern one high byte changed");
	AST_PAT2_LOW_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_PATTERN2_LOW) |=> $stable(userPattern2[7:0]))
		else $error("pattern two low byte changed");
	AST_PAT2_HIGH_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_PATTERN2_HIGH) |=> $stable(userPattern2[15:8]))
		else $error("pattern two high byte changed");
	AST_OR_WRITE_A: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_OVERRANGE_CTRL && chanIndex[0]
		|=> overrangePinEnable[0] == $past(regWdata[0]))
		else $error("channel A over-range enable not written");
	AST_OR_WRITE_B: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_OVERRANGE_CTRL && chanIndex[1]
		|=> overrangePinEnable[1] == $past(regWdata[0]))
		else $error("channel B over-range enable not written");
	AST_OR_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_OVERRANGE_CTRL) |=> $stable(overrangePinEnable))
		else $error("over-range enables changed");
	AST_SRC_WRITE_A: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_CHANNEL_SOURCE && chanIndex[0]
		|=> channelSourceB[0] == $past(regWdata[0]))
		else $error("channel A source select not written");
	AST_SRC_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_CHANNEL_SOURCE) |=> $stable(channelSourceB))
		else $error("source selects changed");
	AST_SYNC_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_SYNC_CTRL && !syncFire
		|=> s_q.sync == $past(regWdata & atsc_pkg::SYNC_WRITE_MASK))
		else $error("sync control not written");
	AST_SYNC_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_SYNC_CTRL) && !syncFire |=> $stable(s_q.sync))
		else $error("sync control changed");
	AST_MISC_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		regWrite && regAddr == atsc_pkg::ADDR_MISC_CTRL
		|=> s_q.misc == $past(regWdata & atsc_pkg::MISC_WRITE_MASK))
		else $error("misc control not written");
	AST_MISC_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!(regWrite && regAddr == atsc_pkg::ADDR_MISC_CTRL) |=> $stable(s_q.misc))
		else $error("misc control changed");

	// Sync, oscillator and output enable checks.
	AST_SINGLE_CLEAR_WINS: assert property (@(posedge sys_clk) disable iff (rst)
		syncFire && s_q.sync[2] |=> !s_q.sync[1])
		else $error("single sync clear lost to a write");
	AST_ALIGN_ON_FIRE: assert property (@(posedge sys_clk) disable iff (rst)
		syncFire |=> dividerAlign)
		else $error("accepted sync did not align");
	AST_NO_FIRE_NO_ALIGN: assert property (@(posedge sys_clk) disable iff (rst)
		!syncFire |=> !dividerAlign)
		else $error("align without accepted sync");
	AST_OSC_DETECT: assert property (@(posedge sys_clk) disable iff (rst)
		s_q.misc[3] && lowRateDetected |=> oscillatorRun)
		else $error("oscillator not started by detector");
	AST_OSC_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
		!s_q.misc[2] && !(s_q.misc[3] && lowRateDetected) |=> !oscillatorRun)
		else $error("oscillator runs without cause");
	AST_OE_PIN: assert property (@(posedge sys_clk) disable iff (rst)
		s_q.misc[7] |=> dataOutputsEnabled == !$past(outputEnablePinN))
		else $error("output enable pin not followed");
endmodule : atsc_regs

//--- inc/atsc_pkg.sv
/*
 * Constants for the test pattern, sync and miscellaneous control registers.
 * Assumes a byte-wide register port with a 9-bit address.
 */
package atsc_pkg;
	localparam logic [8:0] ADDR_PATTERN1_LOW = 9'h019;
	localparam logic [8:0] ADDR_PATTERN1_HIGH = 9'h01a;
	localparam logic [8:0] ADDR_PATTERN2_LOW = 9'h01b;
	localparam logic [8:0] ADDR_PATTERN2_HIGH = 9'h01c;
	localparam logic [8:0] ADDR_SIGNATURE_LOW = 9'h024;
	localparam logic [8:0] ADDR_OVERRANGE_CTRL = 9'h02a;
	localparam logic [8:0] ADDR_CHANNEL_SOURCE = 9'h02e;
	localparam logic [8:0] ADDR_SYNC_CTRL = 9'h100;
	localparam logic [8:0] ADDR_MISC_CTRL = 9'h101;
	localparam logic [7:0] RST_PATTERN = 8'h00;
	localparam logic [7:0] RST_OVERRANGE = 8'h01;
	localparam logic [7:0] RST_SOURCE_CHAN_A = 8'h00;
	localparam logic [7:0] RST_SOURCE_CHAN_B = 8'h01;
	localparam logic [7:0] RST_SYNC = 8'h01;
	localparam logic [7:0] RST_MISC = 8'h88;
	localparam int SYNC_MASTER_BIT = 0;
	localparam int SYNC_DIVIDER_BIT = 1;
	localparam int SYNC_NEXT_ONLY_BIT = 2;
	localparam int MISC_OE_PIN_BIT = 7;
	localparam int MISC_DETECT_BIT = 3;
	localparam int MISC_RUN_OSC_BIT = 2;
	localparam int MISC_PULLDOWN_DIS_BIT = 0;
	localparam logic [7:0] SYNC_WRITE_MASK = 8'h07;
	localparam logic [7:0] MISC_WRITE_MASK = 8'h8d;
	localparam logic [7:0] FLAG_WRITE_MASK = 8'h01;
endpackage : atsc_pkg

//--- verif/adc_test_sync_config_regs_tb.sv
/*
 * Self-checking bench for the register bank with a table loop and hand tests.
 * Assumes the host model drives the register port at the falling edge.
 */
`timescale 1ns/1ps
module adc_test_sync_config_regs_tb;
	logic sys_clk = 1'b0, rst = 1'b1, regWrite, regRead, syncPulse = 1'b0;
	logic lowRateDetected = 1'b0, outputEnablePinN = 1'b1, dividerAlign, oscillatorRun;
	logic dataOutputsEnabled, sdioPulldownDisable;
	logic [8:0] regAddr;
	logic [7:0] regWdata, regRdata, signatureIn = 8'h6e;
	logic [1:0] chanIndex = 2'b11, overrangePinEnable, channelSourceB;
	logic [15:0] userPattern1, userPattern2;
	int failCount = 0, comparisons = 0;
	localparam logic [24:0] ROWS [8] = '{{9'h019, 8'h5a, 8'h5a}, {9'h01a, 8'ha5, 8'ha5},
		{9'h01b, 8'h3c, 8'h3c}, {9'h01c, 8'hc3, 8'hc3}, {9'h024, 8'hff, 8'h6e},
		{9'h100, 8'hff, 8'h07}, {9'h101, 8'hff, 8'h8d}, {9'h0ff, 8'hff, 8'h00}};
	always #12.5 sys_clk = ~sys_clk;
	atsc_host host (.sys_clk(sys_clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
	atsc_regs uut (.sys_clk(sys_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .chanIndex(chanIndex),
		.signatureIn(signatureIn), .syncPulse(syncPulse), .lowRateDetected(lowRateDetected),
		.outputEnablePinN(outputEnablePinN), .userPattern1(userPattern1),
		.userPattern2(userPattern2), .overrangePinEnable(overrangePinEnable),
		.channelSourceB(channelSourceB), .dividerAlign(dividerAlign),
		.oscillatorRun(oscillatorRun), .dataOutputsEnabled(dataOutputsEnabled),
		.sdioPulldownDisable(sdioPulldownDisable));
	task automatic cmpPort(input string what, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : cmpPort
	task automatic rdc(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		cmpPort("regRdata", {8'h00, e}, {8'h00, d});
	endtask : rdc
	task automatic pulse(input logic e);
		@(negedge sys_clk);
		syncPulse = 1'b1;
		@(negedge sys_clk);
		syncPulse = 1'b0;
		cmpPort("dividerAlign", {15'h0000, e}, {15'h0000, dividerAlign});
	endtask : pulse
	task automatic endOfTest;
		$display("comparisons %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : endOfTest
	initial begin
		repeat (5000) @(posedge sys_clk);
		failCount++;
		endOfTest();
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			host.wr(ROWS[i][24:16], ROWS[i][15:8]);
			rdc(ROWS[i][24:16], ROWS[i][7:0]);
		end
		cmpPort("userPattern1", 16'ha55a, userPattern1);
		cmpPort("userPattern2", 16'hc33c, userPattern2);
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		cmpPort("patterns", 16'h0000, userPattern1 | userPattern2);
		cmpPort("pins", 16'h0e80, {4'h0, overrangePinEnable, channelSourceB, dataOutputsEnabled,
			sdioPulldownDisable, 6'h00});
		rdc(9'h100, 8'h01);
		rdc(9'h101, 8'h88);
		chanIndex = 2'b01;
		rdc(9'h02e, 8'h00);
		host.wr(9'h02a, 8'h00);
		cmpPort("overrangePinEnable", 16'h0002, {14'h0000, overrangePinEnable});
		chanIndex = 2'b10;
		rdc(9'h02e, 8'h01);
		rdc(9'h02a, 8'h01);
		pulse(1'b0);
		host.wr(9'h100, 8'h07);
		pulse(1'b1);
		pulse(1'b0);
		rdc(9'h100, 8'h05);
		host.wr(9'h100, 8'h03);
		pulse(1'b1);
		pulse(1'b1);
		host.wr(9'h100, 8'h02);
		pulse(1'b0);
		lowRateDetected = 1'b1;
		repeat (2) @(negedge sys_clk);
		cmpPort("osc detect", 16'h0001, {15'h0000, oscillatorRun});
		cmpPort("oe pin", 16'h0000, {15'h0000, dataOutputsEnabled});
		host.wr(9'h101, 8'h01);
		@(negedge sys_clk);
		cmpPort("osc off", 16'h0000, {15'h0000, oscillatorRun});
		cmpPort("oe ignored", 16'h0001, {15'h0000, dataOutputsEnabled});
		cmpPort("pull", 16'h0001, {15'h0000, sdioPulldownDisable});
		host.wr(9'h101, 8'h04);
		@(negedge sys_clk);
		cmpPort("osc run", 16'h0001, {15'h0000, oscillatorRun});
		endOfTest();
	end
endmodule : adc_test_sync_config_regs_tb

//--- verif/atsc_host.sv
/*
 * Host model that reads and writes the register bank one byte at a time.
 * Assumes the bank takes a strobe at the rising edge and answers one cycle later.
 */
`timescale 1ns/1ps
module atsc_host (
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic regWrite,
	output logic regRead,
	output logic [8:0] regAddr,
	output logic [7:0] regWdata,
	input wire logic [7:0] regRdata
);
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 9'h000;
		regWdata = 8'h00;
	end
	// Released address lines, and the data lines after a write, show the inverse so stale values never pass.
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge sys_clk);
		regWrite = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask : wr
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge sys_clk);
		regRead = 1'b0;
		regAddr = ~a;
		d = regRdata;
	endtask : rd
endmodule : atsc_host
